/* design/bcx_alu.sv */
// Combinational datapath: subtract with flags, bit test, decimal adjust
module bcx_alu
    import bcx_pkg::*;
(
    input wire logic [15:0] opa,
    input wire logic [15:0] opb,
    input wire logic [3:0] pos,
    input wire logic cin,
    input wire logic dc_in,
    output logic [4:0] sub_flags,
    output logic bit_val,
    output logic [15:0] bit_set,
    output logic [15:0] daw_res,
    output logic daw_c,
    output logic sgt,
    output logic slt
);
    logic [16:0] diff;  // Extended difference, msb is carry (no borrow)
    logic [4:0] low;    // Low-nibble difference for half spill
    logic [8:0] adj;    // Decimal-adjusted low byte with carry

    // ************************************************
    // Subtract a - b - ~cin, flags as an add of ~b
    // ************************************************
    always_comb begin
        diff = {1'b0, opa} + {1'b0, ~opb} + {16'h0000, cin};
        low = {1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} + {4'h0, cin};
        sub_flags[FLG_C] = diff[16];
        sub_flags[FLG_DC] = low[4];
        sub_flags[FLG_N] = diff[15];
        sub_flags[FLG_OV] = (opa[15] != opb[15]) && (diff[15] != opa[15]);
        sub_flags[FLG_Z] = (diff[15:0] == 16'h0000);
    end

    // Bit picked by position; set variant forces it to one
    assign bit_val = opa[pos];
    assign bit_set = opa | (16'h0001 << pos);

    // ************************************************
    // Packed decimal correction of the low byte
    // ************************************************
    always_comb begin
        adj = {1'b0, opa[7:0]};
        if (dc_in || (adj[3:0] > 4'h9)) begin
            adj = adj + 9'h006;
        end
        if (cin || adj[8] || (adj[7:4] > 4'h9)) begin
            adj = adj + 9'h060;
        end
        daw_res = {opa[15:8], adj[7:0]};
        // Carry only ever sets; a set input carry is not forced back to clear
        daw_c = cin | adj[8] | (opa[7:4] > 4'h9);
    end

    // Signed ordering for the compare-and-skip group
    assign sgt = $signed(opa) > $signed(opb);
    assign slt = $signed(opa) < $signed(opb);
endmodule

/* design/bcx_exec.sv */
// Top of the execution unit: Avalon-MM slave, sequencer, hold-off counter
module bcx_exec
    import bcx_pkg::*;
#(
    parameter int HOLD_W = 14  // Width of the hold-off count
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic instr_tick,
    input wire logic irq_req,
    input wire logic [2:0] irq_prio,
    output logic irq_take_q,
    output logic exec_done_q
);
    // ************************************************
    // Declarations
    // ************************************************
    logic wait_q;              // Waitrequest flop, high when idle
    logic [31:0] rdata_q;      // Read data flop
    logic [13:0] cmd_q;        // Last command word
    logic [15:0] opa_q;        // Base operand
    logic [22:0] opb_q;        // Second operand, wide for far target
    logic [4:0] flags_q;       // C, DC, N, OV, Z
    logic [15:0] result_q;     // Written-back value
    logic [22:0] target_q;     // Resolved call target
    logic skip_q;              // Last instruction skipped
    logic [1:0] cyc_q;         // Cycles the last instruction took
    logic [HOLD_W-1:0] hold_q; // Instruction cycles left in hold-off
    seq_e state_q;             // Sequencer state
    logic [1:0] need_q;        // Cycles the current instruction needs
    logic [1:0] spent_q;       // Cycles spent so far
    logic hit;                 // Bus access accepted this cycle
    logic cmd_busy;            // Command write must wait
    logic launch;              // Command write takes effect
    op_e op;                   // Decoded opcode
    logic [3:0] pos;           // Bit position
    logic [4:0] sub_flags;
    logic bit_val;
    logic [15:0] bit_set;
    logic [15:0] daw_res;
    logic daw_c;
    logic sgt;
    logic slt;
    logic [15:0] alu_b;        // Subtrahend after form selection
    logic skip_now;            // Skip condition of the current command
    logic [1:0] need_d;        // Cycle need of the current command

    // Byte-lane merge used by every writable register
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ************************************************
    // Datapath
    // ************************************************
    assign op = op_e'(cmd_q[CMD_OP_LSB +: 5]);
    assign pos = cmd_q[CMD_POS_LSB +: 4];
    // Zero compare uses a zero subtrahend
    assign alu_b = (op == OP_CMP_ZERO) ? 16'h0000 : opb_q[15:0];

    bcx_alu u_alu (
        .opa(opa_q),
        .opb(alu_b),
        .pos(pos),
        .cin((op == OP_CMP || op == OP_CMP_ZERO) ? 1'b1 : flags_q[FLG_C]),
        .dc_in(flags_q[FLG_DC]),
        .sub_flags(sub_flags),
        .bit_val(bit_val),
        .bit_set(bit_set),
        .daw_res(daw_res),
        .daw_c(daw_c),
        .sgt(sgt),
        .slt(slt)
    );

    // Skip decision and cycle need
    always_comb begin
        case (op)
            OP_SKIP_CLR: skip_now = !bit_val;
            OP_SKIP_SET: skip_now = bit_val;
            OP_CSK_EQ: skip_now = (opa_q == opb_q[15:0]);
            OP_CSK_GT: skip_now = sgt;
            OP_CSK_LT: skip_now = slt;
            OP_CSK_NE: skip_now = (opa_q != opb_q[15:0]);
            default: skip_now = 1'b0;
        endcase
        if (op == OP_CALL_LIT || op == OP_CALL_IND) begin
            need_d = CYC_CALL;
        end else if (skip_now) begin
            need_d = cmd_q[CMD_NEXT2] ? CYC_SKIP2 : CYC_SKIP1;
        end else begin
            need_d = CYC_PLAIN;
        end
    end

    // ************************************************
    // Avalon-MM slave handshake
    // ************************************************
    // A command write waits while an instruction is still running
    assign cmd_busy = (state_q != S_IDLE) && (avs_address == OFS_CMD);
    assign hit = !wait_q && (avs_read || avs_write);
    assign launch = hit && avs_write && (avs_address == OFS_CMD);

    // Answer one cycle after the request, unless held back
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_q <= 1'b1;
        end else if (wait_q && (avs_read || avs_write) && !(avs_write && cmd_busy)) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end
    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;

    // Read data captured as waitrequest drops; unmapped reads as zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 32'h0000_0000;
        end else if (wait_q && avs_read) begin
            case (avs_address)
                OFS_CMD: rdata_q <= {18'h00000, cmd_q};
                OFS_OPA: rdata_q <= {16'h0000, opa_q};
                OFS_OPB: rdata_q <= {9'h000, opb_q};
                OFS_FLAGS: rdata_q <= {27'h0000000, flags_q};
                OFS_RESULT: rdata_q <= {16'h0000, result_q};
                OFS_INFO: rdata_q <= {27'h0000000, hold_q != '0, cyc_q, skip_q,
                                      state_q != S_IDLE};
                OFS_HOLD: rdata_q <= 32'(hold_q);
                OFS_TARGET: rdata_q <= {9'h000, target_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************
    // Software-written operand registers
    // ************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_q <= 14'h0000;
            opa_q <= 16'h0000;
            opb_q <= 23'h000000;
        end else if (hit && avs_write) begin
            case (avs_address)
                OFS_CMD: cmd_q <= 14'(be_merge(32'(cmd_q), avs_writedata, avs_byteenable));
                OFS_OPA: opa_q <= 16'(be_merge(32'(opa_q), avs_writedata, avs_byteenable));
                OFS_OPB: opb_q <= 23'(be_merge(32'(opb_q), avs_writedata, avs_byteenable));
                default: ;
            endcase
        end
    end

    // ************************************************
    // Sequencer: one state per instruction cycle
    // ************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= S_IDLE;
            need_q <= 2'h0;
            spent_q <= 2'h0;
            exec_done_q <= 1'b0;
        end else begin
            exec_done_q <= 1'b0;
            case (state_q)
                S_IDLE: if (launch) begin
                    state_q <= S_FIRST;
                    spent_q <= 2'h1;
                end
                S_FIRST: begin
                    // Need is fixed in the first cycle, from the operands then present
                    need_q <= need_d;
                    if (need_d == CYC_PLAIN) begin
                        state_q <= S_IDLE;
                        exec_done_q <= 1'b1;
                    end else begin
                        state_q <= S_SECOND;
                        spent_q <= 2'h2;
                    end
                end
                S_SECOND: if (need_q == CYC_SKIP2) begin
                    state_q <= S_THIRD;
                    spent_q <= 2'h3;
                end else begin
                    state_q <= S_IDLE;
                    exec_done_q <= 1'b1;
                end
                S_THIRD: begin
                    state_q <= S_IDLE;
                    exec_done_q <= 1'b1;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Outcome of the last instruction, for software to read
    always_ff @(posedge clk) begin
        if (srst) begin
            skip_q <= 1'b0;
            cyc_q <= 2'h0;
        end else if (state_q == S_FIRST) begin
            skip_q <= skip_now;
            cyc_q <= need_d;
        end
    end

    // ************************************************
    // Flags and write-back, taken in the first cycle
    // ************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            flags_q <= FLAGS_RST;
            result_q <= 16'h0000;
            target_q <= 23'h000000;
        end else if (state_q == S_FIRST) begin
            case (op)
                OP_PROBE, OP_PROBE_SET: begin
                    if (cmd_q[CMD_TO_Z]) begin
                        flags_q[FLG_Z] <= !bit_val;
                    end else begin
                        flags_q[FLG_C] <= bit_val;
                    end
                    // Then-set variant writes the bit back as one
                    result_q <= (op == OP_PROBE_SET) ? bit_set : opa_q;
                end
                OP_CMP, OP_CMP_BRW, OP_CMP_ZERO: flags_q <= sub_flags;
                OP_DEC_ADJ: begin
                    result_q <= daw_res;
                    flags_q[FLG_C] <= daw_c;
                end
                OP_CALL_LIT: target_q <= opb_q;
                OP_CALL_IND: target_q <= {7'h00, opa_q};
                default: ;
            endcase
        end else if (hit && avs_write && avs_address == OFS_FLAGS) begin
            // Software may preset flags, for example carry before a borrow compare
            flags_q <= 5'(be_merge(32'(flags_q), avs_writedata, avs_byteenable));
        end
    end

    // ************************************************
    // Interrupt hold-off counter and gate
    // ************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            hold_q <= '0;
        end else if (state_q == S_FIRST && op == OP_HOLD_OFF) begin
            hold_q <= opb_q[HOLD_W-1:0];
        end else if (instr_tick && hold_q != '0) begin
            hold_q <= hold_q - 1'b1;
        end
    end

    // Level 0 is a disabled source; top level passes the hold-off
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_take_q <= 1'b0;
        end else begin
            irq_take_q <= irq_req && (irq_prio != 3'h0) &&
                          (hold_q == '0 || irq_prio == PRIO_TOP);
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_skip_clear: assert property ((state_q == S_FIRST && op == OP_SKIP_CLR)
        |-> (skip_now == !opa_q[pos])) else $error("skip-clear wrong");
    a_skip_set: assert property ((state_q == S_FIRST && op == OP_SKIP_SET)
        |-> (skip_now == opa_q[pos])) else $error("skip-set wrong");
    a_probe_set: assert property ((state_q == S_FIRST && op == OP_PROBE_SET)
        |=> result_q[$past(pos)] && exec_done_q) else $error("probe-set wrong");
    a_call_two: assert property ((state_q == S_FIRST && (op == OP_CALL_LIT ||
        op == OP_CALL_IND)) |=> (state_q == S_SECOND) ##1 exec_done_q && $stable(flags_q))
        else $error("call not two cycles");
    a_cmp_nil: assert property ((state_q == S_FIRST && op == OP_CMP)
        |=> flags_q[FLG_Z] == ($past(opa_q) == $past(opb_q[15:0])))
        else $error("compare zero flag wrong");
    a_cmp_borrow: assert property ((state_q == S_FIRST && op == OP_CMP_BRW &&
        !flags_q[FLG_C] && opa_q == opb_q[15:0]) |=> !flags_q[FLG_C] && flags_q[FLG_N])
        else $error("borrow compare wrong");
    a_cmp_zero: assert property ((state_q == S_FIRST && op == OP_CMP_ZERO)
        |=> flags_q[FLG_C] && flags_q[FLG_Z] == ($past(opa_q) == 16'h0000))
        else $error("zero compare wrong");
    a_cskip_flags: assert property ((state_q == S_FIRST && op >= OP_CSK_EQ &&
        op <= OP_CSK_NE) |=> $stable(flags_q)) else $error("compare-skip moved flags");
    a_adjust_flags: assert property ((state_q == S_FIRST && op == OP_DEC_ADJ)
        |=> flags_q[4:1] == $past(flags_q[4:1])) else $error("adjust moved flags");
    a_hold_load: assert property ((state_q == S_FIRST && op == OP_HOLD_OFF)
        |=> hold_q == $past(opb_q[HOLD_W-1:0]) && exec_done_q)
        else $error("hold-off not loaded");
    a_skip_cycles: assert property ((state_q == S_FIRST && skip_now && cmd_q[CMD_NEXT2])
        |=> (state_q == S_SECOND) ##1 (state_q == S_THIRD) ##1 exec_done_q)
        else $error("two-word skip not three cycles");
    a_top_passes: assert property ((irq_req && irq_prio == PRIO_TOP)
        |=> irq_take_q) else $error("top level held off");
    a_hold_blocks: assert property ((irq_req && hold_q != '0 && irq_prio != PRIO_TOP)
        |=> !irq_take_q) else $error("low level not held off");
    // Cycles counted by the sequencer must match the cycle figure reported
    a_spent_done: assert property (exec_done_q |-> spent_q == cyc_q)
        else $error("cycle count wrong");

    c_skip_taken: cover property (state_q == S_FIRST && skip_now);
    c_call_done: cover property (state_q == S_FIRST && op == OP_CALL_LIT ##2 exec_done_q);
    c_hold_top: cover property (hold_q != '0 && irq_take_q);
    c_cmd_stall: cover property (avs_write && cmd_busy && wait_q);
endmodule

/* design/bcx_pkg.sv */
// Shared constants, opcodes and register map of the bit/compare/call execution unit
package bcx_pkg;
    // ************************************************
    // Register map (byte addresses, one word each)
    // ************************************************
    localparam logic [5:0] OFS_CMD = 6'h00;   // Opcode and modifiers, write launches
    localparam logic [5:0] OFS_OPA = 6'h04;   // Base operand
    localparam logic [5:0] OFS_OPB = 6'h08;   // Second operand or literal
    localparam logic [5:0] OFS_FLAGS = 6'h0c; // Status flags, read/write
    localparam logic [5:0] OFS_RESULT = 6'h10; // Written-back value
    localparam logic [5:0] OFS_INFO = 6'h14;  // Busy, skip, cycle count
    localparam logic [5:0] OFS_HOLD = 6'h18;  // Remaining hold-off count
    localparam logic [5:0] OFS_TARGET = 6'h1c; // Call target

    // ************************************************
    // Field positions
    // ************************************************
    localparam int CMD_OP_LSB = 0;     // Opcode [4:0]
    localparam int CMD_POS_LSB = 8;    // Bit position [11:8]
    localparam int CMD_TO_Z = 12;      // Probe result goes to zero flag
    localparam int CMD_NEXT2 = 13;     // Following instruction is two words
    localparam int FLG_C = 0;          // Top spill bit
    localparam int FLG_DC = 1;         // Half spill bit
    localparam int FLG_N = 2;          // Msb of result
    localparam int FLG_OV = 3;         // Range exceed
    localparam int FLG_Z = 4;          // Result nil
    localparam int INFO_BUSY = 0;
    localparam int INFO_SKIP = 1;
    localparam int INFO_CYC_LSB = 2;   // Cycles spent [3:2]
    localparam int INFO_HOLD = 4;

    // ************************************************
    // Reset values and counts
    // ************************************************
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [1:0] CYC_PLAIN = 2'h1;  // Single-cycle instruction
    localparam logic [1:0] CYC_CALL = 2'h2;   // Either call form
    localparam logic [1:0] CYC_SKIP1 = 2'h2;  // Skip over one-word instruction
    localparam logic [1:0] CYC_SKIP2 = 2'h3;  // Skip over two-word instruction
    localparam logic [2:0] PRIO_TOP = 3'h7;   // Level never held off

    // Opcodes
    typedef enum logic [4:0] {
        OP_SKIP_CLR = 5'h00, OP_SKIP_SET = 5'h01, OP_PROBE = 5'h02,
        OP_PROBE_SET = 5'h03, OP_CALL_LIT = 5'h04, OP_CALL_IND = 5'h05,
        OP_CMP = 5'h06, OP_CMP_BRW = 5'h07, OP_CMP_ZERO = 5'h08,
        OP_CSK_EQ = 5'h09, OP_CSK_GT = 5'h0a, OP_CSK_LT = 5'h0b,
        OP_CSK_NE = 5'h0c, OP_DEC_ADJ = 5'h0d, OP_HOLD_OFF = 5'h0e
    } op_e;

    // Sequencer states, Gray along idle-first-second-third
    typedef enum logic [1:0] {
        S_IDLE = 2'b00, S_FIRST = 2'b01, S_SECOND = 2'b11, S_THIRD = 2'b10
    } seq_e;
endpackage

/* test/bcx_exec_tb.sv */
// Self-checking bench for the bit/compare/call execution unit
module bcx_exec_tb
    import bcx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [5:0] adr;
    logic rd, wr, tick_go, tick, irq, take, done, wait_r;
    logic [31:0] wdat, rdat, info, flg, res, tgt;
    logic [3:0] be;
    logic [2:0] prio, lvl;
    int n_fail = 0;
    int n_tests = 0;
    // Compare operands: carry, half carry, sign and overflow corners
    logic [15:0] ca [6] = '{16'h0005, 16'h0003, 16'h8000, 16'h7fff, 16'h0010, 16'h0007};
    logic [15:0] cb [6] = '{16'h0003, 16'h0005, 16'h0001, 16'hffff, 16'h0001, 16'h0007};
    bcx_exec u_dut (.clk(clk), .srst(srst), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wait_r), .instr_tick(tick), .irq_req(irq), .irq_prio(prio),
        .irq_take_q(take), .exec_done_q(done));
    seq_model u_seq (.clk(clk), .srst(srst), .tick_go(tick_go), .lvl(lvl),
        .instr_tick(tick), .irq_req(irq), .irq_prio(prio));
    initial begin
        forever #4 clk = ~clk;
    end
    // ************************************************
    // Bus and check tasks
    // ************************************************
    // One Avalon access; request held up to the edge that samples waitrequest low
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wdat <= d;
        // Values read right after the edge are the ones the slave showed before it
        do begin
            @(posedge clk);
            k++;
        end while (wait_r !== 1'b0 && k < 40);
        if (k >= 40) n_fail++;
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Load operands and flags, launch, wait for done, read back results
    task automatic run(input logic [4:0] op, input logic [3:0] pos, input logic [1:0] md,
                       input logic [15:0] a, input logic [22:0] b, input logic [4:0] f);
        logic [31:0] x;
        int k;
        xfer(1'b1, OFS_OPA, {16'h0, a}, x);
        xfer(1'b1, OFS_OPB, {9'h0, b}, x);
        xfer(1'b1, OFS_FLAGS, {27'h0, f}, x);
        xfer(1'b1, OFS_CMD, {18'h0, md, pos, 3'h0, op}, x);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (done !== 1'b1 && k < 10);
        if (k >= 10) n_fail++;
        xfer(1'b0, OFS_INFO, 32'h0, info);
        xfer(1'b0, OFS_FLAGS, 32'h0, flg);
        xfer(1'b0, OFS_RESULT, 32'h0, res);
        xfer(1'b0, OFS_TARGET, 32'h0, tgt);
    endtask
    // Expected subtract flags {Z, OV, N, DC, C}; C and DC mean no borrow
    function automatic logic [4:0] subf(input logic [15:0] a, input logic [15:0] b,
                                        input logic bw);
        logic [16:0] d;
        logic [4:0] h;
        d = {1'b0, a} - {1'b0, b} - {16'h0, bw};
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bw};
        return {d[15:0] == 16'h0, (a[15] != b[15]) && (d[15] != a[15]), d[15], !h[4], !d[16]};
    endfunction
    task automatic print_verdict;
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog: the whole sequence needs under two thousand cycles
    initial begin
        repeat (30000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        logic [31:0] x;
        logic [4:0] f;
        logic e, bv;
        adr = 6'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdat = 32'h0;
        be = 4'hf;
        tick_go = 1'b0;
        lvl = 3'h0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        // Every place reads zero after reset, unmapped one included
        for (int i = 0; i <= 8; i++) begin
            xfer(1'b0, 6'(i * 4), 32'h0, x);
            chk("reset read", 32'h0, x);
        end
        xfer(1'b1, 6'h20, 32'hffffffff, x);
        xfer(1'b1, OFS_HOLD, 32'h5, x);
        xfer(1'b0, OFS_HOLD, 32'h0, x);
        chk("hold ro", 32'h0, x);
        // Bit skips over one- and two-word followers
        for (int i = 0; i < 8; i++) begin
            bv = i[1];
            e = i[0] ? bv : !bv;
            run(i[0] ? OP_SKIP_SET : OP_SKIP_CLR, 4'ha, {i[2], 1'b0},
                bv ? 16'h0400 : 16'hfbff, 23'h0, 5'h15);
            chk("skip info", {28'h0, e ? (i[2] ? CYC_SKIP2 : CYC_SKIP1) : CYC_PLAIN, e, 1'b0}, info);
            chk("skip flags", 32'h15, flg);
        end
        // Compare-skips: signed gt/lt, sign boundary pairs
        for (int i = 0; i < 12; i++) begin
            x = (i % 3 == 0) ? 32'h00050005 : ((i % 3 == 1) ? 32'h80000001 : 32'h00018000);
            e = (i / 3 == 0) ? (x[31:16] == x[15:0]) : (i / 3 == 1) ?
                ($signed(x[31:16]) > $signed(x[15:0])) : (i / 3 == 2) ?
                ($signed(x[31:16]) < $signed(x[15:0])) : (x[31:16] != x[15:0]);
            run(5'(9 + i / 3), 4'h0, 2'b10, x[31:16], {7'h0, x[15:0]}, 5'h0a);
            chk("cskip info", {28'h0, e ? CYC_SKIP2 : CYC_PLAIN, e, 1'b0}, info);
            chk("cskip flags", 32'h0a, flg);
        end
        // Probes to C or Z, plain and then-set; preset flags opposite
        for (int i = 0; i < 8; i++) begin
            bv = i[2];
            f = {bv, 3'b010, !bv};
            run(i[0] ? OP_PROBE_SET : OP_PROBE, bv ? 4'h5 : 4'h4, {1'b0, i[1]}, 16'h0020, 23'h0, f);
            chk("probe flags", {27'h0, i[1] ? {!bv, f[3:0]} : {f[4:1], bv}}, flg);
            chk("probe result", (i[0] && !bv) ? 32'h30 : 32'h20, res);
        end
        // Both call forms: two cycles, flags untouched
        run(OP_CALL_LIT, 4'h0, 2'b00, 16'h0, 23'h7abcde, 5'h1f);
        chk("call info", {28'h0, CYC_CALL, 2'b00}, info);
        chk("call flags", 32'h1f, flg);
        chk("call target", 32'h7abcde, tgt);
        run(OP_CALL_IND, 4'h0, 2'b00, 16'h1234, 23'h0, 5'h0a);
        chk("icall info", {28'h0, CYC_CALL, 2'b00}, info);
        chk("icall flags", 32'h0a, flg);
        chk("icall target", 32'h1234, tgt);
        // Compare, compare with borrow (C in 0 and 1), compare with zero
        for (int i = 0; i < 24; i++) begin
            f = (i % 4 == 1) ? 5'h00 : ((i % 4 == 2) ? 5'h01 : 5'h1e);
            run((i % 4 == 0) ? OP_CMP : ((i % 4 == 3) ? OP_CMP_ZERO : OP_CMP_BRW), 4'h0,
                2'b00, ca[i / 4], {7'h0, cb[i / 4]}, f);
            chk("cmp flags", {27'h0, subf(ca[i / 4], (i % 4 == 3) ? 16'h0 : cb[i / 4], i % 4 == 1)}, flg);
            chk("cmp info", {28'h0, CYC_PLAIN, 2'b00}, info);
        end
        // Decimal adjust: nibble fix, carry set, carry never cleared
        run(OP_DEC_ADJ, 4'h0, 2'b00, 16'h001c, 23'h0, 5'h1c);
        chk("dadj low", 32'h22, res & 32'hff);
        chk("dadj flags", 32'h1c, flg);
        run(OP_DEC_ADJ, 4'h0, 2'b00, 16'h00a0, 23'h0, 5'h1c);
        chk("dadj carry", 32'h1d, flg);
        run(OP_DEC_ADJ, 4'h0, 2'b00, 16'h0012, 23'h0, 5'h1d);
        chk("dadj keep", 32'h1d, flg);
        // Hold-off: level 3 blocked, top level passes, count runs out
        lvl <= 3'h3;
        run(OP_HOLD_OFF, 4'h0, 2'b00, 16'h0, 23'h3, 5'h0a);
        chk("hold flags", 32'h0a, flg);
        xfer(1'b0, OFS_HOLD, 32'h0, x);
        chk("hold count", 32'h3, x);
        chk("held take", 32'h0, {31'h0, take});
        lvl <= 3'h7;
        repeat (3) @(posedge clk);
        chk("top take", 32'h1, {31'h0, take});
        lvl <= 3'h3;
        tick_go <= 1'b1;
        repeat (24) @(posedge clk);
        tick_go <= 1'b0;
        chk("free take", 32'h1, {31'h0, take});
        xfer(1'b0, OFS_HOLD, 32'h0, x);
        chk("hold spent", 32'h0, x);
        print_verdict();
    end
endmodule

/* test/seq_model.sv */
// Behavioural sequencer model: instruction ticks and interrupt requests
module seq_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic tick_go,
    input wire logic [2:0] lvl,
    output logic instr_tick,
    output logic irq_req,
    output logic [2:0] irq_prio
);
    logic [1:0] div_q; // Ticks come four clocks apart, like a slow core
    // Drive ticks and request lines from registers, never mid-cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            div_q <= 2'h0;
            instr_tick <= 1'b0;
            irq_req <= 1'b0;
            irq_prio <= 3'h0;
        end else begin
            div_q <= div_q + 2'h1;
            instr_tick <= tick_go && (div_q == 2'h3);
            irq_req <= (lvl != 3'h0);
            irq_prio <= lvl;
        end
    end
endmodule
